//--- hdl/cps_sequencer.v
// power-on sequencer state machine with apb registers
`timescale 1ns/1ps
`include "cps_defines.vh"
module cps_sequencer
#(
	parameter RETRY_CYC = (`CPS_CLK_HZ / 1000) * `CPS_RETRY_MS,
	parameter DLY_UNIT  = (`CPS_CLK_HZ / 1000) * `CPS_ENABLE_DELAY_FIELD_MS,
	parameter SS_UNIT   = (`CPS_CLK_HZ / 1000) * `CPS_SS_MS,
	parameter LL_UNIT   = (`CPS_CLK_HZ / 1000) * `CPS_LL_MS,
	parameter WD_UNIT   = (`CPS_CLK_HZ / 1000) * `CPS_WD_MS
)
(
	// clock and reset
	input  wire        SYS_CLK,
	input  wire        RESET,
	// apb slave
	input  wire        PSEL,
	input  wire        PENABLE,
	input  wire        PWRITE,
	input  wire [7:0]  PADDR,
	input  wire [31:0] PWDATA,
	output reg  [31:0] PRDATA,
	output reg         PREADY,
	output reg         PSLVERR,
	// pins and analog indications
	input  wire        EN_PIN,
	input  wire        EN_ACTIVE_LOW,
	input  wire [7:0]  VIN_CODE,
	input  wire [7:0]  VIN_DV,
	input  wire [7:0]  DIE_TEMP_C,
	input  wire        LDO_FAULT,
	input  wire        SWITCH_AT_LIMIT,
	input  wire        OUT_IN_REG,
	input  wire        OUT_BELOW_UVP,
	input  wire        LIGHT_LOAD,
	input  wire        BUCK_MODE,
	// outputs
	output reg         CONV_EN,
	output reg         OUT_GOOD_OE,
	output reg         INT_OE,
	output reg  [2:0]  SEQ_STATE
);
	////////////////////////////////////////////////////////////////
	// pin synchronisers
	reg  [1:0] en_s, ldo_s, lim_s, reg_s, uvp_s, ll_s, buck_s;
	always @(posedge SYS_CLK)
	begin
		en_s   <= {en_s[0], EN_PIN};
		ldo_s  <= {ldo_s[0], LDO_FAULT};
		lim_s  <= {lim_s[0], SWITCH_AT_LIMIT};
		reg_s  <= {reg_s[0], OUT_IN_REG};
		uvp_s  <= {uvp_s[0], OUT_BELOW_UVP};
		ll_s   <= {ll_s[0], LIGHT_LOAD};
		buck_s <= {buck_s[0], BUCK_MODE};
	end
	// multi-bit codes are assumed quasi-static; two stages still applied
	reg [7:0] vin1, vin2, vdv1, vdv2, tmp1, tmp2;
	reg       pol1, pol2;
	always @(posedge SYS_CLK)
	begin
		vin1 <= VIN_CODE;
		vin2 <= vin1;
		vdv1 <= VIN_DV;
		vdv2 <= vdv1;
		tmp1 <= DIE_TEMP_C;
		tmp2 <= tmp1;
		pol1 <= EN_ACTIVE_LOW;
		pol2 <= pol1;
	end

	////////////////////////////////////////////////////////////////
	// registers
	reg        standby_r;
	reg [31:0] cfg_r, thr_r, irq_mask_r;
	reg        wd_kick_r, irq_rel_r;
	wire       wr = PSEL & PENABLE & PWRITE & ~PREADY;
	wire       rd = PSEL & PENABLE & ~PWRITE & ~PREADY;
	wire [1:0] enable_delay_field        = cfg_r[`CPS_CFG_ENABLE_DELAY_FIELD_LO +: 2];
	wire [1:0] wd_period                 = cfg_r[`CPS_CFG_WD_LO +: 2];
	wire       ss_long                   = cfg_r[`CPS_CFG_SS];
	wire [1:0] light_load_timeout_field  = cfg_r[`CPS_CFG_LL_LO +: 2];
	wire       ldo_fault_mask            = cfg_r[`CPS_CFG_LDO_MASK];
	wire [7:0] input_low_setting         = thr_r[7:0];
	wire [7:0] input_low_offset_setting  = thr_r[15:8];
	wire [31:0] status_w;

	// apb writes, one wait state; kick and release bits self-clear
	always @(posedge SYS_CLK)
	begin
		if (RESET)
		begin
			standby_r  <= 1'b0;
			cfg_r      <= `CPS_CFG_RESET;
			thr_r      <= `CPS_THR_RESET;
			irq_mask_r <= 32'h0000_0000;
			wd_kick_r  <= 1'b0;
			irq_rel_r  <= 1'b0;
			PREADY     <= 1'b0;
			PSLVERR    <= 1'b0;
			PRDATA     <= 32'h0000_0000;
		end
		else
		begin
			PREADY    <= PSEL & PENABLE & ~PREADY;
			PSLVERR   <= 1'b0;
			wd_kick_r <= 1'b0;
			irq_rel_r <= 1'b0;
			if (wr)
			begin
				case (PADDR)
				`CPS_REG_CTRL:
				begin
					standby_r <= PWDATA[`CPS_CTRL_STANDBY];
					wd_kick_r <= PWDATA[`CPS_CTRL_WD_KICK];
					irq_rel_r <= PWDATA[`CPS_CTRL_IRQ_REL];
				end
				`CPS_REG_CFG:      cfg_r      <= {23'h000000, PWDATA[8:0]};
				`CPS_REG_THR:      thr_r      <= {16'h0000, PWDATA[15:0]};
				`CPS_REG_IRQ_MASK: irq_mask_r <= {26'h0000000, PWDATA[5:0]};
				`CPS_REG_IRQ_CLR:  irq_rel_r  <= PWDATA[0];
				`CPS_REG_STATUS:   PSLVERR    <= 1'b0;
				default:           PSLVERR    <= 1'b1;
				endcase
			end
			if (rd)
			begin
				case (PADDR)
				`CPS_REG_CTRL:     PRDATA <= {31'h00000000, standby_r}; // release bits read zero
				`CPS_REG_CFG:      PRDATA <= cfg_r;
				`CPS_REG_THR:      PRDATA <= thr_r;
				`CPS_REG_STATUS:   PRDATA <= status_w;
				`CPS_REG_IRQ_MASK: PRDATA <= irq_mask_r;
				`CPS_REG_IRQ_CLR:  PRDATA <= 32'h0000_0000;
				default:
				begin
					PRDATA  <= 32'h0000_0000;
					PSLVERR <= 1'b1;
				end
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// power-on request: enable pin with polarity, standby overrides
	wire power_on = (en_s[1] ^ pol2) & ~standby_r;
	reg  power_on_d;
	always @(posedge SYS_CLK)
		power_on_d <= RESET ? 1'b0 : power_on;
	wire leave_power_on = power_on_d & ~power_on;

	////////////////////////////////////////////////////////////////
	// fault detection
	wire [8:0] uv_thr = {1'b0, input_low_offset_setting} - {1'b0, input_low_setting};
	wire uv_fault  = ~uv_thr[8] & ({1'b0, vin2} < uv_thr);
	wire ov_fault  = vdv2 > `CPS_OVP_DV;
	wire ldo_fault = ldo_s[1] & ~ldo_fault_mask;
	reg  ovt_r;
	reg  wd_fault_r;
	reg  oc_r;
	reg  [4:0] lim_cnt_r;
	wire [4:0] oc_lim = cfg_r[`CPS_CFG_OC16] ? 5'h10 : 5'h08;

	// overheat with hysteresis, no mask or clear
	always @(posedge SYS_CLK)
	begin
		if (RESET)
			ovt_r <= 1'b0;
		else if (tmp2 > `CPS_OVT_C)
			ovt_r <= 1'b1;
		else if (tmp2 <= (`CPS_OVT_C - `CPS_HYST_C))
			ovt_r <= 1'b0;
	end

	// overcurrent latch, cleared only leaving power-on; set wins
	always @(posedge SYS_CLK)
	begin
		if (RESET)
		begin
			oc_r      <= 1'b0;
			lim_cnt_r <= 5'h00;
		end
		else
		begin
			lim_cnt_r <= (lim_s[1] & CONV_EN) ? ((lim_cnt_r == oc_lim) ? lim_cnt_r : lim_cnt_r + 5'h01) : 5'h00;
			if (lim_cnt_r == oc_lim)
				oc_r <= 1'b1;
			else if (leave_power_on)
				oc_r <= 1'b0;
		end
	end

	// watchdog: counts period units, kick or zero period clears
	reg [31:0] wd_cnt_r;
	wire [31:0] wd_len = WD_UNIT * {30'h0, wd_period};
	always @(posedge SYS_CLK)
	begin
		if (RESET || wd_kick_r || wd_period == 2'h0)
		begin
			wd_cnt_r   <= 32'h0;
			wd_fault_r <= 1'b0;
		end
		else if (wd_cnt_r >= wd_len - 32'h1)
			wd_fault_r <= 1'b1;
		else
			wd_cnt_r <= wd_cnt_r + 32'h1;
	end

	wire any_fault = uv_fault | ov_fault | ldo_fault | ovt_r | wd_fault_r | oc_r;

	////////////////////////////////////////////////////////////////
	// sequencer
	reg [2:0]  st_r, st_nxt;
	reg [31:0] tmr_r;
	wire [31:0] dly_len = DLY_UNIT * ({30'h0, enable_delay_field} + 32'h1);
	wire [31:0] ss_len  = ss_long ? SS_UNIT * 32'h2 : SS_UNIT;
	wire [31:0] ll_len  = LL_UNIT * ({30'h0, light_load_timeout_field} + 32'h1);
	always @*
	begin
		st_nxt = st_r;
		case (st_r)
		`CPS_ST_HOLD:  if (!any_fault) st_nxt = `CPS_ST_DELAY;
		`CPS_ST_DELAY:
			if (any_fault)
				st_nxt = `CPS_ST_HOLD;
			else if (tmr_r >= dly_len - 32'h1)
				st_nxt = `CPS_ST_SOFT;
		`CPS_ST_SOFT:
			if (any_fault)
				st_nxt = `CPS_ST_HOLD;
			else if (tmr_r >= ss_len - 32'h1 && reg_s[1])
				st_nxt = `CPS_ST_REG;
		`CPS_ST_REG:
			if (any_fault)
				st_nxt = `CPS_ST_HOLD;
			else if (uvp_s[1])
				st_nxt = `CPS_ST_RETRY;
			else if (ll_s[1] && buck_s[1] && tmr_r >= ll_len - 32'h1)
				st_nxt = `CPS_ST_LIGHT;
		`CPS_ST_LIGHT: st_nxt = `CPS_ST_LIGHT;
		`CPS_ST_RETRY: if (tmr_r >= RETRY_CYC - 1) st_nxt = `CPS_ST_HOLD;
		default:       st_nxt = `CPS_ST_HOLD;
		endcase
	end

	// state and timer; timer restarts on each state change
	always @(posedge SYS_CLK)
	begin
		if (RESET || !power_on)
		begin
			st_r  <= `CPS_ST_HOLD;
			tmr_r <= 32'h0;
		end
		else
		begin
			st_r <= st_nxt;
			if (st_nxt != st_r)
				tmr_r <= 32'h0;
			else if (st_r == `CPS_ST_REG && !(ll_s[1] && buck_s[1]))
				tmr_r <= 32'h0; // light load must persist
			else if (tmr_r != 32'hffff_ffff)
				tmr_r <= tmr_r + 32'h1;
		end
	end

	////////////////////////////////////////////////////////////////
	// interrupt: latch on unmasked status change, hold while fault
	wire [5:0] flt = {oc_r, wd_fault_r, ovt_r, ldo_s[1], ov_fault, uv_fault};
	reg  [5:0] flt_d;
	reg        irq_r;
	wire       change = |((flt ^ flt_d) & ~irq_mask_r[5:0]);
	wire       active = |(flt & ~irq_mask_r[5:0]);
	always @(posedge SYS_CLK)
	begin
		if (RESET)
		begin
			flt_d <= 6'h00;
			irq_r <= 1'b0;
		end
		else
		begin
			flt_d <= flt;
			if (change)
				irq_r <= 1'b1;
			else if (irq_rel_r && !active)
				irq_r <= 1'b0;
		end
	end
	// 20 spare bits keep the word at exactly 32 bits
	assign status_w = {20'h00000, st_r, irq_r, flt, CONV_EN, OUT_GOOD_OE};

	// outputs straight from flip-flops
	always @(posedge SYS_CLK)
	begin
		if (RESET)
		begin
			CONV_EN     <= 1'b0;
			OUT_GOOD_OE <= 1'b0;
			INT_OE      <= 1'b0;
			SEQ_STATE   <= `CPS_ST_HOLD;
		end
		else
		begin
			CONV_EN     <= (st_r == `CPS_ST_SOFT) || (st_r == `CPS_ST_REG);
			OUT_GOOD_OE <= (st_r == `CPS_ST_REG) && reg_s[1];
			INT_OE      <= irq_r;
			SEQ_STATE   <= st_r;
		end
	end
endmodule

//--- hdl/cps_defines.vh
// constants for the converter power-on sequencer
// Operation
// - power-on always starts in hold-off, converter off
// - faults clear, enable delay runs, then soft-start
// - input low fault below offset minus setting
// - ldo fault holds hold-off, maskable by bit7
// - watchdog fault cleared by kick or period zero
// - overcurrent latches after 8/16 limit cycles
// - input overvoltage fault self-clears below threshold
// - overheat fault with 30 degree hysteresis, unmaskable
// - soft-start ramps, then regulation when output good
// - fault in soft-start returns to hold-off
// - major fault in regulation returns to hold-off
// - output below 3.0 V enters retry state
// - light-load shutdown only from buck after timeout
// - light-load shutdown held until power-on exits
// - retry keeps converter off 3 s, then restarts
// - enable polarity selectable, active high default
// - output-good low only when enabled and valid
// - interrupt low on unmasked status change
// - interrupt released by self-clearing clear bit
`ifndef CPS_DEFINES_VH
`define CPS_DEFINES_VH
// apb register byte offsets
`define CPS_REG_CTRL      8'h00
`define CPS_REG_CFG       8'h04
`define CPS_REG_THR       8'h08
`define CPS_REG_STATUS    8'h0c
`define CPS_REG_IRQ_MASK  8'h10
`define CPS_REG_IRQ_CLR   8'h14
// ctrl fields
`define CPS_CTRL_STANDBY  0
`define CPS_CTRL_WD_KICK  1
`define CPS_CTRL_IRQ_REL  2
// cfg fields
`define CPS_CFG_ENABLE_DELAY_FIELD_LO 0
`define CPS_CFG_WD_LO     2
`define CPS_CFG_SS        4
`define CPS_CFG_LL_LO     5
`define CPS_CFG_LDO_MASK  7
`define CPS_CFG_OC16      8
`define CPS_CFG_RESET     32'h0000_0000
// threshold fields: offset in [15:8], low setting in [7:0]
`define CPS_THR_RESET     32'h0000_4020
// sequencer state codes
`define CPS_ST_HOLD       3'h0
`define CPS_ST_DELAY      3'h1
`define CPS_ST_SOFT       3'h2
`define CPS_ST_REG        3'h3
`define CPS_ST_LIGHT      3'h4
`define CPS_ST_RETRY      3'h5
// timing in ms, clock rate and fault thresholds
`define CPS_CLK_HZ        25000000
`define CPS_RETRY_MS      3000
`define CPS_ENABLE_DELAY_FIELD_MS     1
`define CPS_SS_MS         2
`define CPS_LL_MS         8
`define CPS_WD_MS         100
`define CPS_OVT_C         160
`define CPS_HYST_C        30
`define CPS_OVP_DV        235
`endif

//--- test/cps_host_model.sv
// host-side model that drives the enable pin
`timescale 1ns/1ps
module cps_host_model
(
	// request and strap
	input  wire want_on,
	input  wire active_low,
	// pin toward the device
	output wire en_pin
);
	////////////////////////////////////////////////////////////
	// the pin follows the request at the strapped polarity
	assign en_pin = want_on ^ active_low;
endmodule

//--- test/cps_seq_sva.sv
// concurrent checks on the sequencer ports
`timescale 1ns/1ps
`include "cps_defines.vh"
module cps_seq_sva
(
	// clock, reset and bus
	input wire        SYS_CLK,
	input wire        RESET,
	input wire        PSEL,
	input wire        PENABLE,
	input wire        PWRITE,
	input wire [7:0]  PADDR,
	input wire [31:0] PWDATA,
	input wire        PREADY,
	// pins and state
	input wire        BUCK_MODE,
	input wire [7:0]  DIE_TEMP_C,
	input wire        CONV_EN,
	input wire        OUT_GOOD_OE,
	input wire        INT_OE,
	input wire [2:0]  SEQ_STATE
);
	localparam int LIM = 1000;
	reg [3:0] rel_cnt_r;
	default clocking @(posedge SYS_CLK); endclocking
	default disable iff (RESET);
	////////////////////////////////////////////////////////////
	// cycles since a release write; saturates so it never looks recent again
	always @(posedge SYS_CLK)
	begin
		if (RESET)
			rel_cnt_r <= 4'hf;
		else if (PSEL && PENABLE && PWRITE && PADDR == `CPS_REG_IRQ_CLR && PWDATA[0])
			rel_cnt_r <= 4'h0;
		else if (rel_cnt_r != 4'hf)
			rel_cnt_r <= rel_cnt_r + 4'h1;
	end
	////////////////////////////////////////////////////////////
	// outputs change on the same edge as the state port
	sequence s_no_buck; (!BUCK_MODE)[*5]; endsequence
	sequence s_hot; (DIE_TEMP_C > 8'd160)[*4]; endsequence
	property p_hold_off; SEQ_STATE == `CPS_ST_HOLD |=> !CONV_EN; endproperty
	a_hold_off: assert property (p_hold_off) else $error("converter on in hold-off");
	property p_soft_in; $rose(SEQ_STATE == `CPS_ST_SOFT) |-> $past(SEQ_STATE) == `CPS_ST_DELAY; endproperty
	a_soft_in: assert property (p_soft_in) else $error("soft-start not after delay");
	property p_soft_on; SEQ_STATE == `CPS_ST_SOFT |-> CONV_EN; endproperty
	a_soft_on: assert property (p_soft_on) else $error("converter off in soft-start");
	property p_soft_out; SEQ_STATE == `CPS_ST_SOFT |=> SEQ_STATE inside {2, 3, 0}; endproperty
	a_soft_out: assert property (p_soft_out) else $error("bad soft-start exit");
	property p_hot; s_hot |-> ##[0:2] SEQ_STATE inside {0, 4, 5}; endproperty
	a_hot: assert property (p_hot) else $error("running while overheated");
	property p_good; SEQ_STATE != `CPS_ST_REG |-> !OUT_GOOD_OE; endproperty
	a_good: assert property (p_good) else $error("output good outside regulation");
	property p_retry; $rose(SEQ_STATE == 5) |=> (SEQ_STATE == 5 && !CONV_EN)[*8]; endproperty
	a_retry: assert property (p_retry) else $error("retry left early");
	property p_retry_end; SEQ_STATE == 5 |-> ##[0:LIM] SEQ_STATE == 0; endproperty
	a_retry_end: assert property (p_retry_end) else $error("retry never restarts");
	property p_light; s_no_buck |-> !(SEQ_STATE == 4 && $past(SEQ_STATE) == 3); endproperty
	a_light: assert property (p_light) else $error("light-load entered outside buck");
	property p_light_stay; SEQ_STATE == 4 |=> SEQ_STATE inside {4, 0}; endproperty
	a_light_stay: assert property (p_light_stay) else $error("light-load left in power-on");
	property p_irq_rel; $fell(INT_OE) |-> rel_cnt_r < 4'h4; endproperty
	a_irq_rel: assert property (p_irq_rel) else $error("interrupt released unasked");
	property p_ready; PSEL && PENABLE && !PREADY |=> PREADY ##1 !PREADY; endproperty
	a_ready: assert property (p_ready) else $error("bus answer late");
endmodule
bind cps_sequencer cps_seq_sva cps_seq_sva_i (.SYS_CLK(SYS_CLK), .RESET(RESET), .PSEL(PSEL), .PENABLE(PENABLE),
	.PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PREADY(PREADY), .BUCK_MODE(BUCK_MODE),
	.DIE_TEMP_C(DIE_TEMP_C), .CONV_EN(CONV_EN), .OUT_GOOD_OE(OUT_GOOD_OE), .INT_OE(INT_OE), .SEQ_STATE(SEQ_STATE));

//--- test/tb_top.sv
// self-checking bench for the power-on sequencer
`timescale 1ns/1ps
`include "cps_defines.vh"
module tb_top;
	localparam RC = 20;
	reg        clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0, on = 1'b0, alow = 1'b0;
	reg        ldo = 1'b0, lim = 1'b0, inreg = 1'b1, uvp = 1'b0, light = 1'b0, buck = 1'b1, er;
	reg [7:0]  addr = 8'h00, vin = 8'h80, vdv = 8'd120, temp = 8'd25;
	reg [31:0] wd = 32'h0, rd;
	wire       pready, pslverr, en, conv, good, irq;
	wire [31:0] prdata;
	wire [2:0] st;
	integer    err_total = 0, tests_run = 0, seed = 30, i, n;
	////////////////////////////////////////////////////////////
	// 25 MHz clock
	always #20 clk = ~clk;
	cps_host_model cps_host_model_i (.want_on(on), .active_low(alow), .en_pin(en));
	cps_sequencer #(.RETRY_CYC(RC), .DLY_UNIT(10), .SS_UNIT(10), .LL_UNIT(10), .WD_UNIT(50)) cps_sequencer_i
	(
		.SYS_CLK(clk), .RESET(rst), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr), .PADDR(addr), .PWDATA(wd),
		.PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .EN_PIN(en), .EN_ACTIVE_LOW(alow), .VIN_CODE(vin),
		.VIN_DV(vdv), .DIE_TEMP_C(temp), .LDO_FAULT(ldo), .SWITCH_AT_LIMIT(lim), .OUT_IN_REG(inreg),
		.OUT_BELOW_UVP(uvp), .LIGHT_LOAD(light), .BUCK_MODE(buck), .CONV_EN(conv), .OUT_GOOD_OE(good),
		.INT_OE(irq), .SEQ_STATE(st)
	);
	////////////////////////////////////////////////////////////
	// shared tasks; all called just after a rising edge
	task chk(input [8*8-1:0] nm, input [31:0] seen, input [31:0] exp);
		tests_run = tests_run + 1;
		if (seen !== exp)
		begin
			err_total = err_total + 1;
			$display("unexpected %0s: expected %h seen %h", nm, exp, seen);
		end
	endtask
	task cyc(input integer k);
		repeat (k) @(posedge clk);
	endtask
	// ready is looked at mid-cycle, where it is settled; the request
	// is released only after the rising edge that samples it high
	task apb(input w, input [7:0] a, input [31:0] d);
		n = 0;
		psel <= 1'b1;
		pwr <= w;
		addr <= a;
		wd <= d;
		@(posedge clk);
		pen <= 1'b1;
		@(negedge clk);
		while (pready !== 1'b1 && n < 20)
		begin
			@(negedge clk);
			n = n + 1;
		end
		rd = prdata;
		er = pslverr;
		@(posedge clk);
		psel <= 1'b0;
		pen <= 1'b0;
		if (n >= 20)
			err_total = err_total + 1;
		@(posedge clk);
	endtask
	task wst(input [2:0] s);
		n = 0;
		while (st !== s && n < 3000)
		begin
			@(posedge clk);
			n = n + 1;
		end
		chk("state", st, s);
	endtask
	// random levels on the fault side of each threshold, on both sides for the input code
	task fault(input integer k, input f);
		case (k)
			0: vin <= f ? 8'($random(seed)) & 8'h1f : 8'h20 + (8'($random(seed)) & 8'h7f);
			1: vdv <= f ? 8'd236 + (8'($random(seed)) & 8'h0f) : 8'd120;
			2: temp <= f ? 8'd161 + (8'($random(seed)) & 8'h3f) : 8'd25;
			default: ldo <= f;
		endcase
	endtask
	task final_report;
		$display("checks %0d mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	////////////////////////////////////////////////////////////
	// hang guard, far beyond the expected run
	initial
	begin
		cyc(20000);
		err_total = err_total + 1;
		final_report;
	end
	////////////////////////////////////////////////////////////
	// main sequence
	initial
	begin
		cyc(12);
		rst <= 1'b0;
		@(posedge clk);
		apb(0, `CPS_REG_THR, 0);
		chk("thr", rd, `CPS_THR_RESET);
		apb(0, `CPS_REG_IRQ_CLR, 0);
		chk("irqclr", rd, 0);
		apb(0, 8'h18, 0);
		chk("slverr", er, 1);
		on <= 1'b1;
		wst(`CPS_ST_DELAY);
		wst(`CPS_ST_REG);
		chk("good", good, 1);
		for (i = 0; i < 4; i = i + 1)
		begin
			fault(i, 1);
			wst(`CPS_ST_HOLD);
			cyc(2);
			chk("conv", conv, 0);
			chk("irq", irq, 1);
			if (i == 2)
				temp <= 8'd140;
			cyc(30);
			chk("held", st, `CPS_ST_HOLD);
			fault(i, 0);
			wst(`CPS_ST_REG);
			apb(1, `CPS_REG_IRQ_CLR, 1);
			cyc(3);
			chk("irqrel", irq, 0);
		end
		apb(1, `CPS_REG_CFG, 32'h80);
		ldo <= 1'b1;
		cyc(20);
		chk("ldomask", st, `CPS_ST_REG);
		ldo <= 1'b0;
		apb(1, `CPS_REG_CFG, 0);
		uvp <= 1'b1;
		wst(`CPS_ST_RETRY);
		for (i = 0; st === `CPS_ST_RETRY && i < 100; i = i + 1)
			@(posedge clk);
		chk("retry", i >= RC - 1 && i <= RC + 2, 1);
		chk("restart", st, `CPS_ST_HOLD);
		uvp <= 1'b0;
		wst(`CPS_ST_REG);
		buck <= 1'b0;
		light <= 1'b1;
		cyc(60);
		chk("nolight", st, `CPS_ST_REG);
		buck <= 1'b1;
		wst(`CPS_ST_LIGHT);
		light <= 1'b0;
		cyc(30);
		chk("light", st, `CPS_ST_LIGHT);
		chk("goodoff", good, 0);
		on <= 1'b0;
		wst(`CPS_ST_HOLD);
		alow <= 1'b1;
		on <= 1'b1;
		wst(`CPS_ST_REG);
		lim <= 1'b1;
		cyc(5);
		lim <= 1'b0;
		cyc(10);
		chk("ocshort", st, `CPS_ST_REG);
		lim <= 1'b1;
		cyc(12);
		lim <= 1'b0;
		cyc(60);
		chk("oclatch", st, `CPS_ST_HOLD);
		on <= 1'b0;
		cyc(4);
		on <= 1'b1;
		wst(`CPS_ST_REG);
		apb(1, `CPS_REG_CFG, 32'h4);
		cyc(30);
		apb(1, `CPS_REG_CTRL, 32'h2);
		cyc(30);
		chk("kicked", st, `CPS_ST_REG);
		wst(`CPS_ST_HOLD);
		apb(1, `CPS_REG_CFG, 0);
		wst(`CPS_ST_REG);
		final_report;
	end
endmodule
